// file: logic/npcfa_params.svh
// register offsets, reset values and codes for the net port config block
// assumes inclusion by bare name from logic files
`ifndef NPCFA_PARAMS_SVH
`define NPCFA_PARAMS_SVH
`define NPCFA_A_ADDR_SRC   4'h0
`define NPCFA_A_IP         4'h1
`define NPCFA_A_MASK       4'h2
`define NPCFA_A_GW         4'h3
`define NPCFA_A_RATE       4'h4
`define NPCFA_A_LOSS_ACT   4'h5
`define NPCFA_A_IDLE_ACT   4'h6
`define NPCFA_A_FB_CMD     4'h7
`define NPCFA_A_FB_REF     4'h8
`define NPCFA_A_FB_DL01    4'h9
`define NPCFA_A_FB_DL23    4'ha
`define NPCFA_A_STATUS     4'hb
`define NPCFA_A_IRQ_STAT   4'hc
`define NPCFA_A_IRQ_MASK   4'hd
`define NPCFA_A_CTRL       4'he
`define NPCFA_A_RUN_CFG    4'hf
`define NPCFA_SRC_PARAM    2'h1
`define NPCFA_SRC_BOOTP    2'h2
`define NPCFA_RATE_AUTO    3'h0
`define NPCFA_RATE_MAX     3'h4
`define NPCFA_ACT_FAULT    3'h0
`define NPCFA_ACT_STOP     3'h1
`define NPCFA_ACT_ZERO     3'h2
`define NPCFA_ACT_HOLD     3'h3
`define NPCFA_ACT_SEND     3'h4
`define NPCFA_REF_MAX      16'hc350
`define NPCFA_BYTE_RST     8'h00
`define NPCFA_WORD_RST     16'h0000
`define NPCFA_CTRL_CLR_FLT 0
`define NPCFA_CTRL_NET_IO  1
`define NPCFA_CTRL_STOPM   4:2
`define NPCFA_CTRL_RELOAD  5
`endif

// file: logic/npcfa_pkg.sv
// types for the net port config block
// assumes npcfa_params.svh for numbers
package npcfa_pkg;
  typedef enum logic [1:0] {NPCFA_NORMAL, NPCFA_LOST, NPCFA_IDLE}
    npcfa_cond_t;
  typedef struct packed {
    logic [15:0] cmd;
    logic [15:0] ref_v;
    logic [63:0] dl;
  } npcfa_io_t;
endpackage : npcfa_pkg

// file: logic/npcfa_sync.sv
// two-flop synchroniser for pin-level inputs
// assumes a single clk domain
`timescale 1ns/1ns
`default_nettype none
module npcfa_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // level
  input  wire logic d,
  output var  logic q
);
  typedef struct packed {logic s1; logic s2;} npcfa_sync_t;
  npcfa_sync_t st_q;
  npcfa_sync_t st_d;
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) st_q <= '0;
    else st_q <= st_d;
  end
  assign q = st_q.s2;
endmodule : npcfa_sync
`default_nettype wire

// file: logic/npcfa_action.sv
// substitutes fallback, zero or held words for network words
// assumes same-clock inputs; output registered by caller
`timescale 1ns/1ns
`default_nettype none
`include "npcfa_params.svh"
module npcfa_action (
  // selection
  input  wire logic       active,
  input  wire logic [2:0] code,
  // words
  input  wire logic [95:0] net_io,
  input  wire logic [95:0] held_io,
  input  wire logic [95:0] fb_io,
  // result
  output var  logic [95:0] drv_io,
  output var  logic        stop_req,
  output var  logic        fault_req
);
  npcfa_pkg::npcfa_io_t r;
  always_comb begin
    r         = net_io;
    stop_req  = 1'b0;
    fault_req = 1'b0;
    if (active) begin
      case (code)
        `NPCFA_ACT_FAULT: fault_req = 1'b1;
        `NPCFA_ACT_STOP:  stop_req = 1'b1;
        `NPCFA_ACT_ZERO: begin
          r.ref_v = `NPCFA_WORD_RST;
          r.dl    = '0;
        end
        `NPCFA_ACT_HOLD: r = held_io;
        `NPCFA_ACT_SEND: r = fb_io;
        default: fault_req = 1'b1;
      endcase
    end
    drv_io = r;
  end
endmodule : npcfa_action
`default_nettype wire

// file: logic/npcfa_top.sv
// Function
// - source code 1 parameters, 2 BOOTP default
// - four static IP bytes, default zero
// - four mask bytes, default zero, parameter mode
// - four gateway bytes, default zero, parameter mode
// - network settings apply only after reset; the code also applies them on a control reload write (bit 5)
// - rate codes 0 auto to 4
// - loss action only with network control I/O
// - on loss, run loss action, default fault
// - on idle, run idle action, default fault
// - code 1 stops by stop method
// - code 2 zeroes reference and datalinks
// - code 3 holds last words
// - code 4 sends fallback words
// - fallback command 0000..ffff, default 0000
// - fallback reference 0..50000, default 0
// - four fallback datalinks, default 0
//
// top of the net port config and fault action block
// assumes avalon-mm master on clk; loss/idle arrive as async pins
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "npcfa_params.svh"
module npcfa_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic [1:0]  avs_response,
  // network side, asynchronous levels
  input  wire logic        comm_lost_pin,
  input  wire logic        scanner_idle_pin,
  // network words, same clock
  input  wire logic [15:0] net_cmd,
  input  wire logic [15:0] net_ref,
  input  wire logic [63:0] net_dl,
  // drive side
  output var  logic [15:0] drv_cmd,
  output var  logic [15:0] drv_ref,
  output var  logic [63:0] drv_dl,
  output var  logic        drv_stop,
  output var  logic [2:0]  drv_stop_method,
  output var  logic        drv_fault,
  output var  logic        subst_active,
  // running network configuration
  output var  logic        run_use_bootp,
  output var  logic [31:0] run_ip,
  output var  logic [31:0] run_mask,
  output var  logic [31:0] run_gw,
  output var  logic [2:0]  run_rate,
  // interrupt
  output var  logic        irq
);
  typedef struct packed {
    logic [1:0]  addr_source_select;
    logic [31:0] ip_byte_setting;
    logic [31:0] mask_byte_setting;
    logic [31:0] gateway_byte_setting;
    logic [2:0]  link_rate_setting;
    logic [2:0]  loss_action_setting;
    logic [2:0]  idle_action_setting;
    logic [15:0] fallback_command_word;
    logic [15:0] fallback_reference;
    logic [63:0] fallback_datalink;
    logic [2:0]  stop_method_setting;
    logic        net_io_sel;
    logic        run_loaded;
    logic [1:0]  run_src;
    logic [31:0] run_ip;
    logic [31:0] run_mask;
    logic [31:0] run_gw;
    logic [2:0]  run_rate;
    logic        run_bootp;
    logic        fault_latch;
    npcfa_pkg::npcfa_cond_t cond;
    logic [95:0] held;
    logic [95:0] drv;
    logic        stop;
    logic        subst;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic [31:0] rdata;
    logic        wait_n;
    logic        wreq;
    logic [1:0]  resp;
  } npcfa_st_t;

  npcfa_st_t st_q;
  npcfa_st_t st_d;
  logic lost_s;
  logic idle_s;
  logic [95:0] act_io;
  logic act_stop;
  logic act_fault;

  npcfa_sync u_sync_lost (
    .clk  (clk),
    .rst_b(rst_b),
    .d    (comm_lost_pin),
    .q    (lost_s)
  );
  npcfa_sync u_sync_idle (
    .clk  (clk),
    .rst_b(rst_b),
    .d    (scanner_idle_pin),
    .q    (idle_s)
  );

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] npcfa_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : npcfa_merge

  // one code check for the rate, loss and idle selectors, so these reject alike
  function automatic logic npcfa_code_ok(input logic [31:0] v,
                                         input logic [2:0]  max);
    return v[2:0] <= max && v[31:3] == '0;
  endfunction : npcfa_code_ok

  // static words count only under parameter addressing
  function automatic logic [31:0] npcfa_static(input logic [1:0]  src,
                                               input logic [31:0] v);
    return (src == `NPCFA_SRC_BOOTP) ? {4{`NPCFA_BYTE_RST}} : v;
  endfunction : npcfa_static

  npcfa_action u_action (
    .active   (st_q.cond != npcfa_pkg::NPCFA_NORMAL),
    .code     ((st_q.cond == npcfa_pkg::NPCFA_LOST) ?
               st_q.loss_action_setting : st_q.idle_action_setting),
    .net_io   ({net_cmd, net_ref, net_dl}),
    .held_io  (st_q.held),
    .fb_io    ({st_q.fallback_command_word, st_q.fallback_reference,
                st_q.fallback_datalink}),
    .drv_io   (act_io),
    .stop_req (act_stop),
    .fault_req(act_fault)
  );

  always_comb begin
    logic [31:0] m;
    logic        acc;
    m     = '0;
    acc   = (avs_read | avs_write) & st_q.wait_n;
    st_d  = st_q;
    st_d.wait_n = 1'b0;
    // one-shot load of the running config after reset
    if (!st_q.run_loaded) begin
      st_d.run_loaded = 1'b1;
      st_d.run_src    = st_q.addr_source_select;
      st_d.run_bootp  = st_q.addr_source_select == `NPCFA_SRC_BOOTP;
      st_d.run_ip     = npcfa_static(st_q.addr_source_select,
                                     st_q.ip_byte_setting);
      st_d.run_mask   = npcfa_static(st_q.addr_source_select,
                                     st_q.mask_byte_setting);
      st_d.run_gw     = npcfa_static(st_q.addr_source_select,
                                     st_q.gateway_byte_setting);
      st_d.run_rate   = st_q.link_rate_setting;
    end
    // condition: loss only counts with network control I/O
    if (lost_s && st_q.net_io_sel) st_d.cond = npcfa_pkg::NPCFA_LOST;
    else if (idle_s) st_d.cond = npcfa_pkg::NPCFA_IDLE;
    else st_d.cond = npcfa_pkg::NPCFA_NORMAL;
    if (st_q.cond == npcfa_pkg::NPCFA_NORMAL) st_d.held = {net_cmd, net_ref,
                                                           net_dl};
    st_d.drv   = act_io;
    st_d.stop  = act_stop | act_fault | st_q.fault_latch;
    st_d.subst = st_q.cond != npcfa_pkg::NPCFA_NORMAL;
    // registers: single-cycle wait then answer
    if (!st_q.wait_n && (avs_read | avs_write)) begin
      st_d.wait_n = 1'b1;
      st_d.resp   = 2'h0;
      case (avs_address)
        `NPCFA_A_ADDR_SRC: m = {30'h0, st_q.addr_source_select};
        `NPCFA_A_IP:       m = st_q.ip_byte_setting;
        `NPCFA_A_MASK:     m = st_q.mask_byte_setting;
        `NPCFA_A_GW:       m = st_q.gateway_byte_setting;
        `NPCFA_A_RATE:     m = {29'h0, st_q.link_rate_setting};
        `NPCFA_A_LOSS_ACT: m = {29'h0, st_q.loss_action_setting};
        `NPCFA_A_IDLE_ACT: m = {29'h0, st_q.idle_action_setting};
        `NPCFA_A_FB_CMD:   m = {16'h0, st_q.fallback_command_word};
        `NPCFA_A_FB_REF:   m = {16'h0, st_q.fallback_reference};
        `NPCFA_A_FB_DL01:  m = st_q.fallback_datalink[31:0];
        `NPCFA_A_FB_DL23:  m = st_q.fallback_datalink[63:32];
        `NPCFA_A_STATUS:   m = {27'h0, st_q.cond == npcfa_pkg::NPCFA_IDLE,
                                st_q.cond == npcfa_pkg::NPCFA_LOST,
                                st_q.subst, st_q.stop, st_q.fault_latch};
        `NPCFA_A_IRQ_STAT: m = {29'h0, st_q.irq_stat};
        `NPCFA_A_IRQ_MASK: m = {29'h0, st_q.irq_mask};
        `NPCFA_A_CTRL:     m = {27'h0, st_q.stop_method_setting,
                                st_q.net_io_sel, 1'b0};
        default:           m = {27'h0, st_q.run_rate, st_q.run_src};
      endcase
      st_d.rdata = avs_read ? m : 32'h0;
      if (avs_write) begin
        m = npcfa_merge(m, avs_writedata, avs_byteenable);
        case (avs_address)
          // out-of-range codes rejected so settings stay legal
          `NPCFA_A_ADDR_SRC:
            if (m[1:0] == `NPCFA_SRC_PARAM || m[1:0] == `NPCFA_SRC_BOOTP)
              st_d.addr_source_select = m[1:0];
            else st_d.resp = 2'h2;
          `NPCFA_A_IP:   st_d.ip_byte_setting = m;
          `NPCFA_A_MASK: st_d.mask_byte_setting = m;
          `NPCFA_A_GW:   st_d.gateway_byte_setting = m;
          `NPCFA_A_RATE:
            if (npcfa_code_ok(m, `NPCFA_RATE_MAX))
              st_d.link_rate_setting = m[2:0];
            else st_d.resp = 2'h2;
          `NPCFA_A_LOSS_ACT:
            if (npcfa_code_ok(m, `NPCFA_ACT_SEND))
              st_d.loss_action_setting = m[2:0];
            else st_d.resp = 2'h2;
          `NPCFA_A_IDLE_ACT:
            if (npcfa_code_ok(m, `NPCFA_ACT_SEND))
              st_d.idle_action_setting = m[2:0];
            else st_d.resp = 2'h2;
          `NPCFA_A_FB_CMD: st_d.fallback_command_word = m[15:0];
          `NPCFA_A_FB_REF:
            if (m[15:0] <= `NPCFA_REF_MAX && m[31:16] == '0)
              st_d.fallback_reference = m[15:0];
            else st_d.resp = 2'h2;
          `NPCFA_A_FB_DL01: st_d.fallback_datalink[31:0] = m;
          `NPCFA_A_FB_DL23: st_d.fallback_datalink[63:32] = m;
          `NPCFA_A_IRQ_STAT: st_d.irq_stat = st_q.irq_stat &
                                             ~avs_writedata[2:0];
          `NPCFA_A_IRQ_MASK: st_d.irq_mask = m[2:0];
          `NPCFA_A_CTRL: begin
            st_d.stop_method_setting = m[`NPCFA_CTRL_STOPM];
            st_d.net_io_sel          = m[`NPCFA_CTRL_NET_IO];
            if (m[`NPCFA_CTRL_CLR_FLT]) st_d.fault_latch = 1'b0;
            if (m[`NPCFA_CTRL_RELOAD]) st_d.run_loaded = 1'b0;
          end
          default: st_d.resp = 2'h2;
        endcase
      end
    end
    // hardware sets win over software clears
    if (act_fault) st_d.fault_latch = 1'b1;
    if (st_d.cond == npcfa_pkg::NPCFA_LOST &&
        st_q.cond != npcfa_pkg::NPCFA_LOST) st_d.irq_stat[0] = 1'b1;
    if (st_d.cond == npcfa_pkg::NPCFA_IDLE &&
        st_q.cond != npcfa_pkg::NPCFA_IDLE) st_d.irq_stat[1] = 1'b1;
    if (act_fault && !st_q.fault_latch) st_d.irq_stat[2] = 1'b1;
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
    if (acc) st_d.wait_n = 1'b0;
    // waitrequest from its own flop, no gate on the port
    st_d.wreq = !st_d.wait_n;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.addr_source_select <= `NPCFA_SRC_BOOTP;
      st_q.link_rate_setting  <= `NPCFA_RATE_AUTO;
      st_q.loss_action_setting <= `NPCFA_ACT_FAULT;
      st_q.idle_action_setting <= `NPCFA_ACT_FAULT;
      st_q.fallback_command_word <= `NPCFA_WORD_RST;
      st_q.fallback_reference <= `NPCFA_WORD_RST;
      st_q.cond <= npcfa_pkg::NPCFA_NORMAL;
      st_q.ip_byte_setting <= {4{`NPCFA_BYTE_RST}};
      st_q.mask_byte_setting <= {4{`NPCFA_BYTE_RST}};
      st_q.gateway_byte_setting <= {4{`NPCFA_BYTE_RST}};
      st_q.fallback_datalink <= {4{`NPCFA_WORD_RST}};
      st_q.net_io_sel <= 1'b0;
      // running copy starts at the defaults, so release shows no step
      st_q.run_src <= `NPCFA_SRC_BOOTP;
      st_q.run_bootp <= 1'b1;
      st_q.run_rate <= `NPCFA_RATE_AUTO;
      st_q.wreq <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = st_q.wreq;
  assign avs_response    = st_q.resp;
  assign {drv_cmd, drv_ref, drv_dl} = st_q.drv;
  assign drv_stop        = st_q.stop;
  assign drv_stop_method = st_q.stop_method_setting;
  assign drv_fault       = st_q.fault_latch;
  assign subst_active    = st_q.subst;
  assign run_use_bootp   = st_q.run_bootp;
  assign run_ip   = st_q.run_ip;
  assign run_mask = st_q.run_mask;
  assign run_gw   = st_q.run_gw;
  assign run_rate = st_q.run_rate;
  assign irq      = st_q.irq;
endmodule : npcfa_top
`default_nettype wire

// file: sim/npcfa_monitor.sv
// checker on the ports of npcfa_top
// assumes binding to npcfa_top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module npcfa_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register bus
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // network pins
  input wire logic        comm_lost_pin,
  input wire logic        scanner_idle_pin,
  // drive side
  input wire logic        drv_stop,
  input wire logic [2:0]  drv_stop_method,
  input wire logic        drv_fault,
  input wire logic        subst_active,
  // running config
  input wire logic        run_use_bootp,
  input wire logic [31:0] run_ip,
  input wire logic [2:0]  run_rate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic cw;
  logic rl;
  // control write on its taking edge, where the block stores it
  assign cw = avs_write && avs_waitrequest && avs_address == 4'he;
  assign rl = cw && avs_writedata[5];
  a_bus_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
  a_bootp_zero: assert property (
    run_use_bootp |-> run_ip == 32'h0) else $error("ip used in bootp");
  a_run_frozen: assert property (
    !$past(rl, 2) |-> $stable({run_use_bootp, run_ip, run_rate}))
    else $error("run cfg moved");
  a_rate_legal: assert property (run_rate <= 3'h4)
    else $error("rate code out of range");
  a_fault_held: assert property (
    drv_fault && !(cw && avs_writedata[0]) |=> drv_fault)
    else $error("fault dropped without clear");
  a_fault_stops: assert property (drv_fault |-> drv_stop)
    else $error("fault without stop");
  a_method_src: assert property (
    $changed(drv_stop_method) |-> $past(cw) || $past(cw, 2))
    else $error("stop method moved without write");
  a_idle_subst: assert property (
    scanner_idle_pin [*8] |-> subst_active) else $error("idle not flagged");
  // eight cycles covers the two sync flops plus the drive registers
  a_quiet_clear: assert property (
    (!comm_lost_pin && !scanner_idle_pin) [*8] |-> !subst_active)
    else $error("flag without cause");
endmodule : npcfa_monitor
bind npcfa_top npcfa_monitor npcfa_monitor_inst (.clk, .rst_b, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .comm_lost_pin,
  .scanner_idle_pin, .drv_stop, .drv_stop_method, .drv_fault, .subst_active,
  .run_use_bootp, .run_ip, .run_rate);
`default_nettype wire

// file: sim/npcfa_scanner.sv
// network scanner model: status pins and i/o words
// assumes the bench sets lose, idle and words after clk edges
`timescale 1ns/1ns
`default_nettype none
module npcfa_scanner (
  // clock
  input  wire logic        clk,
  // bench controls
  input  wire logic        lose,
  input  wire logic        idle,
  input  wire logic [95:0] words,
  // toward the block
  output var  logic        comm_lost_pin,
  output var  logic        scanner_idle_pin,
  output var  logic [15:0] net_cmd,
  output var  logic [15:0] net_ref,
  output var  logic [63:0] net_dl
);
  logic [7:0]  lost_q;
  logic [95:0] junk_q;
  initial begin
    {lost_q, junk_q, comm_lost_pin, scanner_idle_pin} = '0;
    {net_cmd, net_ref, net_dl} = '0;
  end
  // words turn to noise once loss lasts, so holding must not track them
  always @(posedge clk) begin
    lost_q <= {lost_q[6:0], lose};
    junk_q <= {junk_q[94:0], ~junk_q[95]};
    comm_lost_pin <= lose;
    scanner_idle_pin <= idle;
    {net_cmd, net_ref, net_dl} <= lost_q[7] ? junk_q : words;
  end
endmodule : npcfa_scanner
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for npcfa_top
// assumes npcfa_scanner model and the bound monitor
`timescale 1ns/1ns
`default_nettype none
`include "npcfa_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
  localparam logic [95:0] FB_W = 96'hffff_c350_4444_3333_2222_1111;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, run_ip, run_mask, run_gw, rd_v;
  logic [1:0]  avs_response, rs_v;
  logic        avs_waitrequest, irq, drv_stop, drv_fault, subst_active;
  logic        lose = 1'b0;
  logic        idle = 1'b0;
  logic [95:0] words = 96'h0;
  logic        comm_lost_pin, scanner_idle_pin, run_use_bootp;
  logic [15:0] net_cmd, net_ref, drv_cmd, drv_ref;
  logic [63:0] net_dl, drv_dl;
  logic [2:0]  drv_stop_method, run_rate;
  int          fails = 0;
  int          compares = 0;
  always #4 clk = ~clk;
  npcfa_scanner npcfa_scanner_inst (.clk, .lose, .idle, .words,
    .comm_lost_pin, .scanner_idle_pin, .net_cmd, .net_ref, .net_dl);
  npcfa_top npcfa_top_inst (.clk, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .avs_response, .comm_lost_pin, .scanner_idle_pin,
    .net_cmd, .net_ref, .net_dl, .drv_cmd, .drv_ref, .drv_dl, .drv_stop,
    .drv_stop_method, .drv_fault, .subst_active, .run_use_bootp, .run_ip,
    .run_mask, .run_gw, .run_rate, .irq);
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic acc(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd_v = avs_readdata;
    rs_v = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      fails++;
      end_sim;
    end
  endtask : acc
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    acc(1'b1, a, d, 4'hf);
    `CHK(rs_v, e)
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'hf);
    `CHK(rd_v, e)
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic t_defaults;
    rdc(`NPCFA_A_ADDR_SRC, 32'h2);
    for (int i = 1; i < 5; i++) rdc(4'(i), 32'h0);
    rdc(`NPCFA_A_LOSS_ACT, 32'h0);
    rdc(`NPCFA_A_IDLE_ACT, 32'h0);
    for (int i = 7; i < 11; i++) rdc(4'(i), 32'h0);
    rdc(`NPCFA_A_RUN_CFG, 32'h2);
    `CHK(run_use_bootp, 1'b1)
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_settings;
    wr(`NPCFA_A_ADDR_SRC, 32'h1, 2'h0);
    wr(`NPCFA_A_ADDR_SRC, 32'h3, 2'h2);
    rdc(`NPCFA_A_ADDR_SRC, 32'h1);
    wr(`NPCFA_A_IP, 32'h0a0b0c0d, 2'h0);
    acc(1'b1, `NPCFA_A_IP, 32'hffffffff, 4'h1);
    rdc(`NPCFA_A_IP, 32'h0a0b0cff);
    wr(`NPCFA_A_MASK, 32'hffffff00, 2'h0);
    wr(`NPCFA_A_GW, 32'h0a0b0c01, 2'h0);
    wr(`NPCFA_A_RATE, 32'h5, 2'h2);
    wr(`NPCFA_A_RATE, 32'h4, 2'h0);
    wr(`NPCFA_A_FB_REF, 32'hc351, 2'h2);
    wr(`NPCFA_A_FB_REF, 32'hc350, 2'h0);
    wr(`NPCFA_A_FB_CMD, 32'hffff, 2'h0);
    for (int c = 0; c < 6; c++)
      wr(`NPCFA_A_LOSS_ACT, 32'(c), {c == 5, 1'b0});
    wr(`NPCFA_A_RUN_CFG, 32'h0, 2'h2);
    rdc(`NPCFA_A_RUN_CFG, 32'h2);
    `CHK({run_use_bootp, run_rate}, 4'h8)
    `CHK({run_ip, run_mask, run_gw}, 96'h0)
    $display("test settings done");
  endtask : t_settings
  task automatic t_actions;
    logic [95:0] w;
    wr(`NPCFA_A_CTRL, 32'h16, 2'h0);
    wr(`NPCFA_A_FB_DL01, 32'h22221111, 2'h0);
    wr(`NPCFA_A_FB_DL23, 32'h44443333, 2'h0);
    for (int c = 1; c < 5; c++) begin
      w = {16'h1000 + 16'(c), 80'h0123_4567_89ab_cdef_5a5a};
      words <= w;
      wr(`NPCFA_A_LOSS_ACT, 32'(c), 2'h0);
      lose <= 1'b1;
      cyc(16);
      `CHK(subst_active, 1'b1)
      `CHK(drv_stop, c == 1)
      if (c == 1) `CHK(drv_stop_method, 3'h5)
      if (c == 2) `CHK({drv_ref, drv_dl}, 80'h0)
      if (c == 3) `CHK({drv_cmd, drv_ref, drv_dl}, w)
      if (c == 4) `CHK({drv_cmd, drv_ref, drv_dl}, FB_W)
      lose <= 1'b0;
      cyc(10);
      `CHK(subst_active, 1'b0)
    end
    $display("test actions done");
  endtask : t_actions
  task automatic t_gating;
    wr(`NPCFA_A_CTRL, 32'h14, 2'h0);
    lose <= 1'b1;
    cyc(16);
    `CHK({subst_active, drv_stop, drv_fault}, 3'h0)
    lose <= 1'b0;
    wr(`NPCFA_A_IDLE_ACT, 32'h2, 2'h0);
    idle <= 1'b1;
    cyc(16);
    `CHK({subst_active, drv_ref, drv_dl}, {1'b1, 80'h0})
    idle <= 1'b0;
    cyc(10);
    $display("test gating done");
  endtask : t_gating
  task automatic t_fault;
    logic q;
    wr(`NPCFA_A_CTRL, 32'h16, 2'h0);
    wr(`NPCFA_A_LOSS_ACT, 32'h0, 2'h0);
    wr(`NPCFA_A_IRQ_STAT, 32'h7, 2'h0);
    lose <= 1'b1;
    cyc(16);
    lose <= 1'b0;
    cyc(10);
    `CHK({drv_fault, drv_stop, subst_active}, 3'h6)
    rdc(`NPCFA_A_IRQ_STAT, 32'h5);
    rdc(`NPCFA_A_STATUS, 32'h3);
    wr(`NPCFA_A_IRQ_MASK, 32'h0, 2'h0);
    cyc(2);
    q = irq;
    wr(`NPCFA_A_IRQ_MASK, 32'h7, 2'h0);
    cyc(2);
    `CHK(q, 1'b0)
    `CHK(irq, 1'b1)
    wr(`NPCFA_A_CTRL, 32'h17, 2'h0);
    cyc(2);
    `CHK(drv_fault, 1'b0)
    wr(`NPCFA_A_IRQ_STAT, 32'h7, 2'h0);
    rdc(`NPCFA_A_IRQ_STAT, 32'h0);
    cyc(2);
    `CHK(irq, 1'b0)
    $display("test fault done");
  endtask : t_fault
  task automatic t_reload;
    wr(`NPCFA_A_CTRL, 32'h20, 2'h0);
    cyc(2);
    `CHK({run_use_bootp, run_rate}, 4'h4)
    `CHK(run_ip, 32'h0a0b0cff)
    `CHK(run_mask, 32'hffffff00)
    `CHK(run_gw, 32'h0a0b0c01)
    rdc(`NPCFA_A_RUN_CFG, 32'h11);
    rst_b <= 1'b0;
    cyc(3);
    rst_b <= 1'b1;
    rdc(`NPCFA_A_ADDR_SRC, 32'h2);
    rdc(`NPCFA_A_IP, 32'h0);
    `CHK({run_use_bootp, run_ip, run_rate}, {1'b1, 35'h0})
    $display("test reload done");
  endtask : t_reload
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_defaults;
    t_settings;
    t_actions;
    t_gating;
    t_fault;
    t_reload;
    end_sim;
  end
endmodule : tb
`default_nettype wire
